// ---- src/mqps_top.sv ----
// Multi-queue port setup, programming chain, queue flags and register slave.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module mqps_top
   import mqps_pkg::*;
#(
   parameter int QW = 2,
   parameter int DEPTH = 32,
   parameter int IMG_BITS = 16
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] port_width_select,
   input wire logic default_mode_select,
   input wire logic queue_strap_low_bit,
   input wire logic queue_strap_high_bit,
   input wire logic prog_chain_in,
   input wire logic serial_prog_clk,
   input wire logic serial_in,
   output logic serial_out,
   output logic prog_chain_out,
   input wire logic wr_en_n,
   input wire logic [35:0] wr_data,
   input wire logic wr_queue_sel,
   input wire logic [QW-1:0] wr_queue_addr,
   output logic queue_full_n,
   input wire logic rd_en_n,
   input wire logic rd_queue_sel,
   input wire logic [QW-1:0] rd_queue_addr,
   output logic [35:0] rd_data,
   output logic out_ready_n
);
   localparam int NQ = 1 << QW;
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam int IC = $clog2(IMG_BITS);

   if (QW < 1 || DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0 ||
       IMG_BITS < 2 || IMG_BITS > 32) begin : g_bad
      $error("mqps_top: unsupported parameter values");
   end

   // Maps a width code to 9-bit units per word of the write or read port.
   function automatic logic [2:0] units_of(input logic [3:0] code,
                                           input logic rd);
      logic [2:0] w;
      logic [2:0] r;
      w = MQPS_UNITS_36;
      r = MQPS_UNITS_36;
      case (code)
         MQPS_BM_36_18: r = MQPS_UNITS_18;
         MQPS_BM_36_9: r = MQPS_UNITS_9;
         MQPS_BM_18_36: w = MQPS_UNITS_18;
         MQPS_BM_18_18: begin
            w = MQPS_UNITS_18;
            r = MQPS_UNITS_18;
         end
         MQPS_BM_18_9: begin
            w = MQPS_UNITS_18;
            r = MQPS_UNITS_9;
         end
         MQPS_BM_9_36: w = MQPS_UNITS_9;
         MQPS_BM_9_18: begin
            w = MQPS_UNITS_9;
            r = MQPS_UNITS_18;
         end
         MQPS_BM_9_9: begin
            w = MQPS_UNITS_9;
            r = MQPS_UNITS_9;
         end
         default: ;
      endcase
      return rd ? r : w;
   endfunction

   logic [9:0] pin_s1;
   logic [9:0] pin_s2;
   logic [3:0] bm_code;
   logic [2:0] wu;
   logic [2:0] ru;
   logic serial_mode;
   mqps_prog_t pstate;
   logic [IC-1:0] img_cnt;
   logic [IMG_BITS-1:0] image;
   logic sclk_d;
   logic word_fall_through;
   logic [QW-1:0] wq;
   logic [QW-1:0] fq;
   logic [1:0] wsw;
   logic [QW-1:0] rq;
   logic [QW-1:0] rq_pend;
   logic [1:0] rsw;
   logic [8:0] mem [NQ][DEPTH];
   logic [AW-1:0] wp [NQ];
   logic [AW-1:0] rp [NQ];
   logic [CW-1:0] cnt [NQ];
   logic [CW-1:0] next_cnt [NQ];
   logic [35:0] rd_word;
   logic aw_full;
   logic w_full;
   logic [31:0] waddr_q;
   logic [31:0] wdat_q;
   logic [3:0] wstrb_q;
   logic [31:0] rmux;
   logic rerr;

   //////////////////////////////////////////////////////////////////////////
   // Strap and programming pins pass two flip-flops before any logic sees them.
   always_ff @(posedge aclk) begin
      pin_s1 <= {serial_in, serial_prog_clk, prog_chain_in,
                 queue_strap_high_bit, queue_strap_low_bit,
                 default_mode_select, port_width_select};
      pin_s2 <= pin_s1;
   end

   wire [3:0] bm_s = pin_s2[3:0];
   wire ser_strap = !pin_s2[4] && pin_s2[5] && pin_s2[6];
   wire cin_s = pin_s2[7];
   wire sclk_s = pin_s2[8];
   wire sin_s = pin_s2[9];
   wire shift_en = sclk_s && !sclk_d && !cin_s;
   wire img_last = img_cnt == IC'(IMG_BITS - 1);
   wire prog_ok = pstate == MQPS_DONE;

   // Straps are caught while reset is held and frozen at its release.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bm_code <= bm_s;
         wu <= units_of(bm_s, 1'b0);
         ru <= units_of(bm_s, 1'b1);
         serial_mode <= ser_strap;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Register bus handshakes: write address and data in either order.
   wire aw_hs = s_axi_awvalid && s_axi_awready;
   wire w_hs = s_axi_wvalid && s_axi_wready;
   wire wr_do = aw_full && w_full && !s_axi_bvalid;
   wire next_bvalid = wr_do || (s_axi_bvalid && !s_axi_bready);
   wire next_aw_full = (aw_full || aw_hs) && !wr_do;
   wire next_w_full = (w_full || w_hs) && !wr_do;
   wire ctrl_wr = wr_do && waddr_q == MQPS_CTRL_ADDR && wstrb_q[0];
   wire pdone_req = ctrl_wr && wdat_q[MQPS_CTRL_PDONE];
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire next_rvalid = ar_hs || (s_axi_rvalid && !s_axi_rready);
   wire [31:0] ctrl_word = 32'(word_fall_through) << MQPS_CTRL_WORD_FALL_THROUGH;
   wire [31:0] status_word = (32'(prog_chain_out) << MQPS_ST_CHAIN) |
      (32'(serial_mode) << MQPS_ST_SERIAL) |
      (32'(queue_full_n) << MQPS_ST_FULLN) |
      (32'(out_ready_n) << MQPS_ST_ORN) | (32'(bm_code) << MQPS_ST_WIDTH);

   // Read address decode; unmapped offsets answer with a slave error.
   always_comb begin
      rmux = '0;
      rerr = 1'b0;
      if (s_axi_araddr == MQPS_CTRL_ADDR) begin
         rmux = ctrl_word;
      end else if (s_axi_araddr == MQPS_STATUS_ADDR) begin
         rmux = status_word;
      end else if (s_axi_araddr == MQPS_IMAGE_ADDR) begin
         rmux = 32'(image);
      end else begin
         rerr = 1'b1;
      end
   end

   // Write channel state and the response.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= MQPS_OKAY;
         word_fall_through <= MQPS_WORD_FALL_THROUGH_RESET;
      end else begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         s_axi_awready <= !next_aw_full && !next_bvalid;
         s_axi_wready <= !next_w_full && !next_bvalid;
         s_axi_bvalid <= next_bvalid;
         if (wr_do) begin
            s_axi_bresp <= waddr_q == MQPS_CTRL_ADDR ? MQPS_OKAY
                                                     : MQPS_SLVERR;
         end
         if (ctrl_wr) begin
            word_fall_through <= wdat_q[MQPS_CTRL_WORD_FALL_THROUGH];
         end
      end
   end

   // Captured write address and data.
   always_ff @(posedge aclk) begin
      if (aw_hs) begin
         waddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
         wdat_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end
   end

   // Read channel: one read at a time, answered the cycle after address.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= MQPS_OKAY;
      end else begin
         s_axi_arready <= !next_rvalid;
         s_axi_rvalid <= next_rvalid;
         if (ar_hs) begin
            s_axi_rdata <= rmux;
            s_axi_rresp <= rerr ? MQPS_SLVERR : MQPS_OKAY;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Programming sequence: serial shift-in or software-ended parallel mode.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pstate <= MQPS_WAIT;
         img_cnt <= '0;
         image <= '0;
         sclk_d <= 1'b0;
      end else begin
         sclk_d <= sclk_s;
         case (pstate)
            MQPS_WAIT: begin
               if (serial_mode) begin
                  pstate <= MQPS_SHIFT;
               end else if (pdone_req) begin
                  pstate <= MQPS_DONE;
               end
            end
            MQPS_SHIFT: begin
               if (shift_en) begin
                  image <= {image[IMG_BITS-2:0], sin_s};
                  img_cnt <= img_cnt + 1'b1;
                  if (img_last) begin
                     pstate <= MQPS_DONE;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // Chain output high and serial output low until done, then low or transparent in serial mode.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prog_chain_out <= 1'b1;
         serial_out <= 1'b0;
      end else begin
         prog_chain_out <= prog_ok ? serial_mode && cin_s : 1'b1;
         serial_out <= prog_ok && serial_mode && sin_s;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Queue selection and the flag queue that lags the write selection.
   wire wsel_ok = wr_queue_sel && prog_ok;
   wire rsel_ok = rd_queue_sel && prog_ok;
   wire [QW-1:0] next_fq = (wsw == 2'h1 && !wsel_ok) ? wq : fq;
   wire commit = rsw == 2'h1 && !rsel_ok;
   wire [QW-1:0] q_src = commit ? rq_pend : rq;
   wire avail_src = cnt[q_src] >= CW'(ru);
   wire wspace = cnt[wq] <= CW'(DEPTH) - CW'(wu);
   wire wr_acc = prog_ok && !wr_en_n && queue_full_n && wspace;
   wire pop_word_fall_through = commit || out_ready_n || !rd_en_n;
   wire pop_std = !rd_en_n && !commit;
   wire rd_pop = prog_ok && avail_src && (word_fall_through ? pop_word_fall_through : pop_std);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wq <= '0;
         fq <= '0;
         wsw <= '0;
         rq <= '0;
         rq_pend <= '0;
         rsw <= '0;
      end else begin
         fq <= next_fq;
         if (wsel_ok) begin
            wq <= wr_queue_addr;
            wsw <= MQPS_WSW_CYCLES;
         end else if (wsw != 2'h0) begin
            wsw <= wsw - 2'h1;
         end
         if (rsel_ok) begin
            rq_pend <= rd_queue_addr;
            rsw <= MQPS_RSW_CYCLES;
         end else if (rsw != 2'h0) begin
            rsw <= rsw - 2'h1;
         end
         if (commit) begin
            rq <= rq_pend;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Unit counts per queue; writes add write-width, reads take read-width.
   always_comb begin
      for (int i = 0; i < NQ; i++) begin
         next_cnt[i] = cnt[i]
            + ((wr_acc && wq == QW'(i)) ? CW'(wu) : '0)
            - ((rd_pop && q_src == QW'(i)) ? CW'(ru) : '0);
      end
   end

   // Pointers and counts.
   always_ff @(posedge aclk) begin
      for (int i = 0; i < NQ; i++) begin
         if (!aresetn) begin
            cnt[i] <= '0;
            wp[i] <= '0;
            rp[i] <= '0;
         end else begin
            cnt[i] <= next_cnt[i];
            if (wr_acc && wq == QW'(i)) begin
               wp[i] <= wp[i] + AW'(wu);
            end
            if (rd_pop && q_src == QW'(i)) begin
               rp[i] <= rp[i] + AW'(ru);
            end
         end
      end
   end

   // Write words split into 9-bit units, lowest unit first.
   always_ff @(posedge aclk) begin
      for (int k = 0; k < MQPS_MAX_UNITS; k++) begin
         if (wr_acc && k < int'(wu)) begin
            mem[wq][wp[wq] + AW'(k)] <=
               wr_data[MQPS_UNIT_BITS*k +: MQPS_UNIT_BITS];
         end
      end
   end

   // Read word gathered from units in the same order; upper units read zero.
   always_comb begin
      rd_word = '0;
      for (int k = 0; k < MQPS_MAX_UNITS; k++) begin
         if (k < int'(ru)) begin
            rd_word[MQPS_UNIT_BITS*k +: MQPS_UNIT_BITS] =
               mem[q_src][rp[q_src] + AW'(k)];
         end
      end
   end

   // Output register, output-ready flag and full flag.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_data <= '0;
         out_ready_n <= 1'b1;
         queue_full_n <= 1'b0;
      end else begin
         if (rd_pop) begin
            rd_data <= rd_word;
         end
         if (word_fall_through) begin
            out_ready_n <= !rd_pop &&
               (out_ready_n || commit || !rd_en_n);
         end else begin
            out_ready_n <= next_cnt[commit ? rq_pend : rq] < CW'(ru);
         end
         queue_full_n <= prog_ok &&
            next_cnt[next_fq] <= CW'(DEPTH) - CW'(wu);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Checks on the behaviour above.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_chain_done;
      pstate == MQPS_DONE && !serial_mode |=> !prog_chain_out;
   endproperty
   a_chain_done: assert property (p_chain_done)
      else $error("chain output not low after parallel programming");

   property p_chain_pass;
      pstate == MQPS_DONE && serial_mode |=>
         prog_chain_out == $past(cin_s) && serial_out == $past(sin_s);
   endproperty
   a_chain_pass: assert property (p_chain_pass)
      else $error("chain not transparent after serial load");

   property p_no_reload;
      pstate == MQPS_DONE |=> pstate == MQPS_DONE && $stable(image);
   endproperty
   a_no_reload: assert property (p_no_reload)
      else $error("serial load accepted after programming");

   property p_full_switch;
      wsel_ok ##1 !wsel_ok [*3] |=> fq == wq;
   endproperty
   a_full_switch: assert property (p_full_switch)
      else $error("full flag queue not switched after three cycles");

   property p_full_block;
      !queue_full_n && !rd_pop |=> cnt[$past(wq)] == $past(cnt[wq]);
   endproperty
   a_full_block: assert property (p_full_block)
      else $error("write taken while full flag low");

   property p_fill_flag;
      wr_acc && fq == wq && wsw == 2'h0 && !wsel_ok && !rd_pop &&
         next_cnt[wq] > CW'(DEPTH) - CW'(wu) |=> !queue_full_n;
   endproperty
   a_fill_flag: assert property (p_fill_flag)
      else $error("full flag not low after filling write");

   property p_rd_switch;
      rsel_ok ##1 !rsel_ok [*3] |=> rq == rq_pend;
   endproperty
   a_rd_switch: assert property (p_rd_switch)
      else $error("read queue switch not done in four cycles");

   property p_rd_old;
      rsel_ok |=> $stable(rq) [*3];
   endproperty
   a_rd_old: assert property (p_rd_old)
      else $error("read queue changed before switch completed");

   property p_first_word;
      word_fall_through && out_ready_n && !commit && avail_src && prog_ok
         |=> !out_ready_n;
   endproperty
   a_first_word: assert property (p_first_word)
      else $error("first word did not fall through");

   property p_last_word;
      word_fall_through && !out_ready_n && !rd_en_n && !commit && !avail_src
         |=> out_ready_n && $stable(rd_data);
   endproperty
   a_last_word: assert property (p_last_word)
      else $error("last word read without output-ready going high");

   property p_hold;
      rd_en_n && !out_ready_n && !commit |=> $stable(rd_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("output word changed with reads disabled");
endmodule

// ---- inc/mqps_pkg.sv ----
// Package: constants and types of the multi-queue setup and flag block.
// Notes on behaviour
// - Width straps pick write/read widths from nine codes: x36, x18, x9.
// - Finished parallel programming drives the chain output low.
// - After own serial load, chain input and serial data pass through.
// - Once programming is complete, further serial loads are refused.
// - Full flag shows old write queue three cycles after new selection.
// - Fall-through: new read queue word appears three cycles after select.
// - Writes while the full flag is low are ignored.
// - A write that fills the selected queue drives the full flag low.
// - Fall-through: first word into empty queue shows one cycle later.
// - A read queue switch takes four cycles.
// - During a read switch, enabled reads still use the old queue.
// - Reading the last word raises output-ready; the word stays on bus.
// - Read enable high holds the output word while output-ready is low and no read switch commits.
// - Output-ready stays low while the read queue holds more words.
// - Standard mode: empty new queue leaves the last word on output.
// - Width straps sampled at reset; one width per port for all queues.
// - Full counting uses words of the write-port width.
// - Empty counting uses words of the read-port width.
// - Mixed widths pack and unpack in little-endian order.
package mqps_pkg;
   localparam logic [3:0] MQPS_BM_36_36 = 4'h0;
   localparam logic [3:0] MQPS_BM_36_18 = 4'h1;
   localparam logic [3:0] MQPS_BM_36_9 = 4'h2;
   localparam logic [3:0] MQPS_BM_18_36 = 4'h3;
   localparam logic [3:0] MQPS_BM_9_36 = 4'h4;
   localparam logic [3:0] MQPS_BM_18_18 = 4'h5;
   localparam logic [3:0] MQPS_BM_18_9 = 4'h6;
   localparam logic [3:0] MQPS_BM_9_18 = 4'h7;
   localparam logic [3:0] MQPS_BM_9_9 = 4'h9;
   localparam logic [2:0] MQPS_UNITS_36 = 3'h4;
   localparam logic [2:0] MQPS_UNITS_18 = 3'h2;
   localparam logic [2:0] MQPS_UNITS_9 = 3'h1;
   localparam int MQPS_UNIT_BITS = 9;
   localparam int MQPS_MAX_UNITS = 4;
   localparam logic [31:0] MQPS_CTRL_ADDR = 32'h0000_0000;
   localparam logic [31:0] MQPS_STATUS_ADDR = 32'h0000_0004;
   localparam logic [31:0] MQPS_IMAGE_ADDR = 32'h0000_0008;
   localparam int MQPS_CTRL_WORD_FALL_THROUGH = 0;
   localparam int MQPS_CTRL_PDONE = 1;
   localparam logic MQPS_WORD_FALL_THROUGH_RESET = 1'b0;
   localparam int MQPS_ST_CHAIN = 0;
   localparam int MQPS_ST_SERIAL = 1;
   localparam int MQPS_ST_FULLN = 2;
   localparam int MQPS_ST_ORN = 3;
   localparam int MQPS_ST_WIDTH = 8;
   localparam logic [1:0] MQPS_WSW_CYCLES = 2'h3;
   localparam logic [1:0] MQPS_RSW_CYCLES = 2'h3;
   localparam logic [1:0] MQPS_OKAY = 2'h0;
   localparam logic [1:0] MQPS_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      MQPS_WAIT = 2'b00,
      MQPS_SHIFT = 2'b01,
      MQPS_DONE = 2'b11
   } mqps_prog_t;
endpackage

// ---- tb/mqps_ctl_model.sv ----
// Programming controller model: mode straps and chain inputs.
`timescale 1ns/10ps
module mqps_ctl_model (
   input wire logic aclk,
   output logic default_mode_select,
   output logic queue_strap_low_bit,
   output logic queue_strap_high_bit,
   output logic prog_chain_in,
   output logic serial_prog_clk,
   output logic serial_in
);
   logic pattern;
   ///////////////////////////////////////////////////////////////////////
   // Parallel mode: mode select high keeps the part out of serial mode.
   assign default_mode_select = 1'b1;
   assign queue_strap_low_bit = 1'b0;
   assign queue_strap_high_bit = 1'b0;
   // Chain input held low for the whole parallel operation.
   assign prog_chain_in = 1'b0;
   // The serial clock is unused in parallel mode and stays low.
   assign serial_prog_clk = 1'b0;
   // The unused data line changes every cycle so no stale level is seen.
   assign serial_in = pattern;
   // Toggle source for the data line.
   always @(posedge aclk) begin
      pattern <= ~pattern;
   end
   initial begin
      pattern = 1'b0;
   end
endmodule

// ---- tb/multi_queue_port_setup_and_flags_tb.sv ----
// Self-checking bench of the multi-queue setup and flag block.
`timescale 1ns/10ps
module multi_queue_port_setup_and_flags_tb;
   import mqps_pkg::*;
   localparam int DEPTH = 32;
   logic aclk, aresetn;
   logic [31:0] awaddr, wdata, araddr, rdata, v;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp, resp;
   logic [3:0] strap;
   logic dms, qsl, qsh, chain_in, sclk, sin, sout, chain_out;
   logic wr_en_n, wr_sel, full_n, rd_en_n, rd_sel, or_n;
   logic [1:0] wq, rq;
   logic [35:0] wr_data, rd_data, held;
   logic [35:0] q[$];
   logic [3:0] codes[9];
   int errors, num_checks, n;
   mqps_top #(.QW(2), .DEPTH(DEPTH), .IMG_BITS(16)) i_mqps_top (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .port_width_select(strap), .default_mode_select(dms),
      .queue_strap_low_bit(qsl), .queue_strap_high_bit(qsh),
      .prog_chain_in(chain_in), .serial_prog_clk(sclk),
      .serial_in(sin), .serial_out(sout), .prog_chain_out(chain_out),
      .wr_en_n(wr_en_n), .wr_data(wr_data), .wr_queue_sel(wr_sel),
      .wr_queue_addr(wq), .queue_full_n(full_n), .rd_en_n(rd_en_n),
      .rd_queue_sel(rd_sel), .rd_queue_addr(rq), .rd_data(rd_data),
      .out_ready_n(or_n));
   mqps_ctl_model i_mqps_ctl_model (.aclk(aclk),
      .default_mode_select(dms), .queue_strap_low_bit(qsl),
      .queue_strap_high_bit(qsh), .prog_chain_in(chain_in),
      .serial_prog_clk(sclk), .serial_in(sin));
   ////////////////////////////////////////////////////////////////////////
   // Clock of 10 ns period.
   always #5 aclk = ~aclk;
   // Write-port 9-bit units per word of each width code.
   function automatic int wr_units(input logic [3:0] c);
      case (c)
         MQPS_BM_18_36, MQPS_BM_18_18, MQPS_BM_18_9: return MQPS_UNITS_18;
         MQPS_BM_9_36, MQPS_BM_9_18, MQPS_BM_9_9: return MQPS_UNITS_9;
         default: return MQPS_UNITS_36;
      endcase
   endfunction
   // Compare of multi-bit values.
   task automatic chk_val(input logic [35:0] got, input logic [35:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Compare of single flags.
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected flag at %0t: got %b want %b", $time, got, exp);
      end
   endtask
   // Bus write: address and data offered together, released when taken.
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask
   // Bus read: address held until taken, data taken with rvalid.
   task automatic axi_rd(input logic [31:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   // Master reset with the width strap steady.
   task automatic do_reset(input logic [3:0] c);
      @(posedge aclk);
      strap <= c;
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
   endtask
   // One-cycle queue select pulse on either port.
   task automatic sel(input bit rd, input logic [1:0] a);
      @(posedge aclk);
      if (rd) begin rd_sel <= 1'b1; rq <= a; end
      else begin wr_sel <= 1'b1; wq <= a; end
      @(posedge aclk);
      rd_sel <= 1'b0;
      wr_sel <= 1'b0;
   endtask
   // Final verdict.
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog against a hang.
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      tally_and_finish();
   end
   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      aclk = 0; aresetn = 0; strap = MQPS_BM_18_18;
      awaddr = 0; wdata = 0; araddr = 0; awvalid = 0; wvalid = 0;
      bready = 0; arvalid = 0; rready = 0; wr_en_n = 1; rd_en_n = 1;
      wr_sel = 0; rd_sel = 0; wq = 0; rq = 0; wr_data = 0;
      errors = 0; num_checks = 0;
      codes = '{MQPS_BM_36_36, MQPS_BM_36_18, MQPS_BM_36_9, MQPS_BM_18_36,
         MQPS_BM_18_18, MQPS_BM_18_9, MQPS_BM_9_36, MQPS_BM_9_18,
         MQPS_BM_9_9};
      v = $urandom(32'h024b);
      foreach (codes[i]) begin
         do_reset(codes[i]);
         axi_rd(MQPS_STATUS_ADDR);
         chk_val(36'(v[11:8]), 36'(codes[i]));
      end
      do_reset(MQPS_BM_18_18);
      chk_bit(chain_out, 1'b1);
      chk_bit(full_n, 1'b0);
      axi_rd(32'h0000_0010);
      chk_val(36'(resp), 36'(MQPS_SLVERR));
      axi_wr(MQPS_STATUS_ADDR, 32'h0000_0000);
      chk_val(36'(resp), 36'(MQPS_SLVERR));
      axi_wr(MQPS_CTRL_ADDR, 32'h0000_0003);
      chk_val(36'(resp), 36'(MQPS_OKAY));
      n = 0;
      while (chain_out !== 1'b0 && n < 20) begin @(posedge aclk); n++; end
      chk_bit(chain_out, 1'b0);
      // Port traffic only after programming completes.
      sel(0, 2'h1);
      repeat (4) @(posedge aclk);
      wr_en_n <= 1'b0;
      wr_data <= 36'($urandom) & 36'h3ffff;
      n = 0;
      forever begin
         @(posedge aclk);
         if (full_n !== 1'b1) break;
         q.push_back(wr_data);
         n++;
         wr_data <= 36'($urandom) & 36'h3ffff;
      end
      wr_en_n <= 1'b1;
      n = n * wr_units(MQPS_BM_18_18);
      chk_val(36'(n), 36'(DEPTH));
      // Move to an empty queue: the flag shows the old one first.
      sel(0, 2'h2);
      @(posedge aclk);
      #1 chk_bit(full_n, 1'b0);
      repeat (3) @(posedge aclk);
      #1 chk_bit(full_n, 1'b1);
      axi_rd(MQPS_STATUS_ADDR);
      chk_bit(v[MQPS_ST_CHAIN], 1'b0);
      sel(1, 2'h1);
      @(posedge aclk);
      #1 chk_bit(or_n, 1'b1);
      repeat (2) @(posedge aclk);
      #1 chk_val(rd_data, q[0]);
      chk_bit(or_n, 1'b0);
      repeat (3) @(posedge aclk);
      #1 chk_val(rd_data, q[0]);
      @(posedge aclk);
      rd_en_n <= 1'b0;
      for (int i = 1; i < q.size(); i++) begin
         @(posedge aclk);
         #1 chk_val(rd_data, q[i]);
         chk_bit(or_n, 1'b0);
      end
      @(posedge aclk);
      rd_en_n <= 1'b1;
      held = q[q.size() - 1];
      #1 chk_bit(or_n, 1'b1);
      chk_val(rd_data, held);
      // First word into the empty queue selected on both ports.
      sel(0, 2'h1);
      repeat (3) @(posedge aclk);
      wr_en_n <= 1'b0;
      wr_data <= 36'($urandom) & 36'h3ffff;
      @(posedge aclk);
      wr_en_n <= 1'b1;
      held = wr_data;
      repeat (2) @(posedge aclk);
      #1 chk_val(rd_data, held);
      chk_bit(or_n, 1'b0);
      // Standard mode: an empty new read queue leaves the last word out.
      axi_wr(MQPS_CTRL_ADDR, 32'h0000_0000);
      sel(1, 2'h2);
      repeat (5) @(posedge aclk);
      #1 chk_val(rd_data, held);
      chk_bit(or_n, 1'b1);
      tally_and_finish();
   end
endmodule
